// file: common/cee_alu_if.sv
// Purpose: operand/operator bundle between sequencer and arithmetic unit
// Assumes: purely combinational answer
// Notes:   a is the left operand, or the only one for square root
`timescale 1ns/1ps
interface cee_alu_if;
    import cee_pkg::*;
    cee_val_t a;     // left operand
    cee_val_t b;     // right operand
    cee_tok_t op;    // operator token
    logic     gate;  // gate state for switch tokens
    cee_val_t y;     // result
    modport seq (output a, b, op, gate, input y);
    modport alu (input a, b, op, gate, output y);
endinterface : cee_alu_if

// file: common/cee_cfg.svh
// Purpose: constants for the calculation equation evaluator
// Assumes: 100 MHz core clock
// Notes:   token codes, widths, reset values and timing counts
`ifndef CEE_CFG_SVH
`define CEE_CFG_SVH

// data and equation sizes
`define CEE_VAL_W        16
`define CEE_TOK_W        6
`define CEE_EQ_LEN       9
`define CEE_NUM_OPND     27
`define CEE_NUM_GATE     10
`define CEE_SELF_IDX     5'd23

// token codes
`define CEE_TOK_BLANK    6'h00
`define CEE_TOK_OPND0    6'h01
`define CEE_TOK_OPNDL    6'h1b
`define CEE_TOK_GATE0    6'h20
`define CEE_TOK_GATE9    6'h29
`define CEE_TOK_OPEN     6'h30
`define CEE_TOK_SQRT     6'h31
`define CEE_TOK_CLOSE    6'h32
`define CEE_TOK_MUL      6'h33
`define CEE_TOK_DIV      6'h34
`define CEE_TOK_SUB      6'h35
`define CEE_TOK_ADD      6'h36
`define CEE_TOK_HSEL     6'h37
`define CEE_TOK_LSEL     6'h38

// reset values
`define CEE_RESULT_RST   16'h0000

// saturation limits
`define CEE_VAL_MAX      16'h7fff
`define CEE_VAL_MIN      16'h8000

// timing
`define CEE_CLK_HZ       100000000
`define CEE_GATE_PERIOD_MS 100
`define CEE_GATE_CYC     ((`CEE_GATE_PERIOD_MS) * ((`CEE_CLK_HZ) / 1000))
`define CEE_GTMR_W       24

`endif

// file: common/cee_pkg.sv
// Purpose: types for the calculation equation evaluator
// Assumes: cee_cfg.svh defines widths
// Notes:   whole state of the evaluator is one packed struct
`include "cee_cfg.svh"
package cee_pkg;
    typedef logic [`CEE_TOK_W-1:0]        cee_tok_t;
    typedef logic signed [`CEE_VAL_W-1:0] cee_val_t;

    // evaluation sequencer, gray along idle-scan-drain
    typedef enum logic [1:0] {
        EV_IDLE  = 2'b00,
        EV_SCAN  = 2'b01,
        EV_DRAIN = 2'b11
    } cee_ev_e;

    // token categories
    typedef enum logic [2:0] {
        CAT_BLANK, CAT_OPND, CAT_GATE, CAT_OPEN, CAT_CLOSE, CAT_BINOP
    } cee_cat_e;

    typedef struct packed {
        cee_ev_e                         ev;      // sequencer
        logic [3:0]                      pos;     // token position
        logic [3:0]                      vsp;     // value stack depth
        logic [3:0]                      osp;     // operator stack depth
        logic [`CEE_EQ_LEN-1:0][`CEE_VAL_W-1:0] vstk;
        logic [`CEE_EQ_LEN-1:0][`CEE_TOK_W-1:0] ostk;
        logic [`CEE_EQ_LEN-1:0][`CEE_TOK_W-1:0] eq;   // active equation
        logic [`CEE_EQ_LEN-1:0][`CEE_TOK_W-1:0] ebuf; // edit copy
        logic [3:0]                      cursor;  // edit cursor
        logic                            editing; // entry in progress
        logic                            pend;    // commit waiting
        cee_val_t                        result;  // last result
        logic                            res_vld; // result pulse
        cee_tok_t                        edtok;   // token under cursor
        logic [`CEE_NUM_GATE-1:0]        gsnap;   // gate snapshot
        logic [3:0]                      gidx;    // gate refresh index
        logic [`CEE_GTMR_W-1:0]          gtmr;    // refresh timer
    } cee_state_s;
endpackage : cee_pkg

// file: core/cee_alu.sv
// Purpose: combinational arithmetic for one operator
// Assumes: signed integer values
// Notes:   every result saturates to the value range
`timescale 1ns/1ps
module cee_alu
    import cee_pkg::*;
(
    cee_alu_if.alu p
);
    // clamp a 17-bit sum to 16 bits
    function automatic cee_val_t sat17(logic signed [16:0] v);
        if (v > 17'sh07fff) return `CEE_VAL_MAX;
        if (v < -17'sh08000) return `CEE_VAL_MIN;
        return v[15:0];
    endfunction : sat17

    // clamp a 32-bit product to 16 bits
    function automatic cee_val_t sat32(logic signed [31:0] v);
        if (v > 32'sh00007fff) return `CEE_VAL_MAX;
        if (v < -32'sh00008000) return `CEE_VAL_MIN;
        return v[15:0];
    endfunction : sat32

    // bitwise integer square root, negative gives zero
    function automatic cee_val_t isqrt(cee_val_t x);
        logic [7:0]  r;
        logic [7:0]  t;
        logic [15:0] sq;
        r = 8'h00;
        if (x[15]) return 16'h0000;
        for (int i = 7; i >= 0; i--) begin
            t  = r | (8'h01 << i);
            sq = {8'h00, t} * {8'h00, t};
            if (sq <= x) r = t;
        end
        return {8'h00, r};
    endfunction : isqrt

    // operator select
    always_comb begin
        case (p.op)
            `CEE_TOK_ADD:  p.y = sat17(17'(p.a) + 17'(p.b));
            `CEE_TOK_SUB:  p.y = sat17(17'(p.a) - 17'(p.b));
            `CEE_TOK_MUL:  p.y = sat32(32'(p.a) * 32'(p.b));
            `CEE_TOK_DIV: begin
                if (p.b == 16'sh0000) begin
                    p.y = p.a[15] ? `CEE_VAL_MIN :
                          (p.a == 16'sh0000) ? 16'h0000 : `CEE_VAL_MAX;
                end else if (p.a == `CEE_VAL_MIN && p.b == 16'shffff) begin
                    p.y = `CEE_VAL_MAX;
                end else begin
                    p.y = p.a / p.b;
                end
            end
            `CEE_TOK_HSEL: p.y = (p.a > p.b) ? p.a : p.b;
            `CEE_TOK_LSEL: p.y = (p.a < p.b) ? p.a : p.b;
            `CEE_TOK_SQRT: p.y = isqrt(p.a);
            default: begin
                // gate tokens: left on true, right on false
                p.y = p.gate ? p.a : p.b;
            end
        endcase
    end
endmodule : cee_alu

// file: core/cee_evaluator.sv
// Purpose: stored equation evaluator with keypad editor
// Assumes: keys and ticks are one-cycle strobes from same-clock logic
// Notes:   operator-precedence scan, one token or one reduction a cycle
//
// Contract
// - equation holds at most nine tokens
// - unmatched open closes after last token
// - unmatched close opens before first token
// - square root opens group, rooted afterwards
// - gate picks left when true, else right
// - gates zero to nine usable as switches
// - brackets, gates, selects, muldiv, addsub, left-right
// - chained high selects give overall maximum
// - one evaluation per tick, own result readable
// - back moves left, aborts at first position
// - category change blanks tokens right of cursor
// - greater-than high select, less-than low select
// - blank token ends the equation
// - gate snapshot refreshed ascending every 100 ms
`timescale 1ns/1ps
`include "cee_cfg.svh"
module cee_evaluator
    import cee_pkg::*;
#(
    parameter int unsigned GATE_REFRESH_CYC = `CEE_GATE_CYC
) (
    input  wire logic                     clk_i,       // core clock
    input  wire logic                     rst_i,       // async reset
    input  wire logic                     ce_i,        // clock enable
    input  wire logic                     calc_tick_i, // computation cycle
    input  wire cee_val_t                 operands_i [`CEE_NUM_OPND],
    input  wire logic [`CEE_NUM_GATE-1:0] gates_i,     // gate outputs
    input  wire logic                     key_edit_i,  // start entry
    input  wire logic                     key_up_i,    // next token
    input  wire logic                     key_down_i,  // previous token
    input  wire logic                     key_ack_i,   // accept token
    input  wire logic                     key_back_i,  // cursor left
    output logic [`CEE_VAL_W-1:0]         result_o,    // last result
    output logic                          result_valid_o,
    output logic                          busy_o,      // evaluating
    output logic                          editing_o,   // entry active
    output logic [3:0]                    cursor_o,    // edit cursor
    output logic [`CEE_TOK_W-1:0]         edit_tok_o   // token at cursor
);
    cee_state_s s_ff;      // registered state
    cee_state_s nxt_s;     // next state
    cee_alu_if  alu_bus(); // operator bundle

    // token category decode
    function automatic cee_cat_e tok_cat(cee_tok_t t);
        if (t == `CEE_TOK_BLANK) return CAT_BLANK;
        if (t <= `CEE_TOK_OPNDL) return CAT_OPND;
        if (t >= `CEE_TOK_GATE0 && t <= `CEE_TOK_GATE9)
            return CAT_GATE;
        if (t == `CEE_TOK_OPEN || t == `CEE_TOK_SQRT) return CAT_OPEN;
        if (t == `CEE_TOK_CLOSE) return CAT_CLOSE;
        return CAT_BINOP;
    endfunction : tok_cat

    // operator tier, higher binds first
    function automatic logic [2:0] prec(cee_tok_t t);
        case (t)
            `CEE_TOK_HSEL, `CEE_TOK_LSEL: return 3'd3;
            `CEE_TOK_MUL,  `CEE_TOK_DIV:  return 3'd2;
            `CEE_TOK_ADD,  `CEE_TOK_SUB:  return 3'd1;
            default: return (tok_cat(t) == CAT_GATE) ? 3'd4 : 3'd0;
        endcase
    endfunction : prec

    // keypad stepping through the legal codes
    function automatic cee_tok_t tok_step(cee_tok_t t, logic up);
        cee_tok_t n;
        n = up ? t + 6'h01 : t - 6'h01;
        if (up) begin
            if (t == `CEE_TOK_OPNDL) n = `CEE_TOK_GATE0;
            if (t == `CEE_TOK_GATE9) n = `CEE_TOK_OPEN;
            if (t == `CEE_TOK_LSEL)  n = `CEE_TOK_BLANK;
        end else begin
            if (t == `CEE_TOK_BLANK) n = `CEE_TOK_LSEL;
            if (t == `CEE_TOK_OPEN)  n = `CEE_TOK_GATE9;
            if (t == `CEE_TOK_GATE0) n = `CEE_TOK_OPNDL;
        end
        return n;
    endfunction : tok_step

    // apply the stacked operator on top to the value stack
    function automatic cee_state_s apply_top(cee_state_s s, cee_val_t y);
        cee_tok_t t;
        t = s.ostk[s.osp - 4'h1];
        if (t == `CEE_TOK_SQRT) begin
            if (s.vsp != 4'h0) s.vstk[s.vsp - 4'h1] = y;
        end else if (t != `CEE_TOK_OPEN && s.vsp >= 4'h2) begin
            s.vstk[s.vsp - 4'h2] = y;
            s.vsp = s.vsp - 4'h1;
        end
        s.osp = s.osp - 4'h1;
        return s;
    endfunction : apply_top

    // operator on top of stack and the values under it
    cee_tok_t   top_tok;  // top operator
    cee_cat_e   top_cat;  // its category
    cee_val_t   v_top;    // top value
    cee_val_t   v_sec;    // value below top
    logic [3:0] gsel;     // gate number of top operator

    always_comb begin
        top_tok = (s_ff.osp != 4'h0) ? s_ff.ostk[s_ff.osp - 4'h1]
                                     : `CEE_TOK_BLANK;
        top_cat = tok_cat(top_tok);
        v_top   = (s_ff.vsp != 4'h0) ? s_ff.vstk[s_ff.vsp - 4'h1] : '0;
        v_sec   = (s_ff.vsp > 4'h1)  ? s_ff.vstk[s_ff.vsp - 4'h2] : '0;
        gsel    = top_tok[3:0];
    end

    // operands to the arithmetic unit
    assign alu_bus.a    = (top_tok == `CEE_TOK_SQRT) ? v_top : v_sec;
    assign alu_bus.b    = v_top;
    assign alu_bus.op   = top_tok;
    assign alu_bus.gate = (gsel < 4'd10) ? s_ff.gsnap[gsel] : 1'b0;

    cee_alu u_alu (
        .p (alu_bus.alu)
    );

    // next-state logic for sequencer, editor and gate refresh
    always_comb begin
        cee_tok_t   cur;    // token under scan
        cee_cat_e   ccat;   // its category
        cee_tok_t   ntok;   // stepped edit token
        logic [4:0] oidx;   // operand index
        cur  = `CEE_TOK_BLANK;
        ccat = CAT_BLANK;
        ntok = `CEE_TOK_BLANK;
        oidx = 5'd0;
        nxt_s = s_ff;
        nxt_s.res_vld = 1'b0;

        // gate snapshot, one gate per cycle in ascending order
        if (s_ff.gtmr == `CEE_GTMR_W'(GATE_REFRESH_CYC - 1)) begin
            nxt_s.gtmr = '0;
            nxt_s.gidx = 4'h0;
        end else begin
            nxt_s.gtmr = s_ff.gtmr + `CEE_GTMR_W'(1);
        end
        if (s_ff.gidx < 4'd10) begin
            nxt_s.gsnap[s_ff.gidx] = gates_i[s_ff.gidx];
            nxt_s.gidx = s_ff.gidx + 4'h1;
        end

        // evaluation sequencer
        case (s_ff.ev)
            EV_IDLE: begin
                if (s_ff.pend) begin
                    nxt_s.eq   = s_ff.ebuf;
                    nxt_s.pend = 1'b0;
                end
                if (calc_tick_i) begin
                    nxt_s.ev  = EV_SCAN;
                    nxt_s.pos = 4'h0;
                    nxt_s.vsp = 4'h0;
                    nxt_s.osp = 4'h0;
                end
            end
            EV_SCAN: begin
                if (s_ff.pos < 4'd9) cur = s_ff.eq[s_ff.pos];
                ccat = tok_cat(cur);
                case (ccat)
                    CAT_BLANK: nxt_s.ev = EV_DRAIN;
                    CAT_OPND: begin
                        oidx = 5'(cur - `CEE_TOK_OPND0);
                        nxt_s.vstk[s_ff.vsp] = (oidx == `CEE_SELF_IDX)
                            ? s_ff.result : operands_i[oidx];
                        nxt_s.vsp = s_ff.vsp + 4'h1;
                        nxt_s.pos = s_ff.pos + 4'h1;
                    end
                    CAT_OPEN: begin
                        nxt_s.ostk[s_ff.osp] = cur;
                        nxt_s.osp = s_ff.osp + 4'h1;
                        nxt_s.pos = s_ff.pos + 4'h1;
                    end
                    CAT_CLOSE: begin
                        if (s_ff.osp == 4'h0) begin
                            nxt_s.pos = s_ff.pos + 4'h1;
                        end else if (top_cat == CAT_OPEN) begin
                            nxt_s = apply_top(nxt_s, alu_bus.y);
                            nxt_s.pos = s_ff.pos + 4'h1;
                        end else begin
                            nxt_s = apply_top(nxt_s, alu_bus.y);
                        end
                    end
                    default: begin
                        // binary or switch operator, left to right per tier
                        if ((top_cat == CAT_BINOP || top_cat == CAT_GATE)
                            && prec(top_tok) >= prec(cur)) begin
                            nxt_s = apply_top(nxt_s, alu_bus.y);
                        end else begin
                            nxt_s.ostk[s_ff.osp] = cur;
                            nxt_s.osp = s_ff.osp + 4'h1;
                            nxt_s.pos = s_ff.pos + 4'h1;
                        end
                    end
                endcase
            end
            EV_DRAIN: begin
                if (s_ff.osp != 4'h0) begin
                    nxt_s = apply_top(nxt_s, alu_bus.y);
                end else begin
                    nxt_s.result  = (s_ff.vsp != 4'h0) ? s_ff.vstk[0]
                                                       : `CEE_RESULT_RST;
                    nxt_s.res_vld = 1'b1;
                    nxt_s.ev      = EV_IDLE;
                end
            end
            default: nxt_s.ev = EV_IDLE;
        endcase

        // keypad editor on a private copy
        if (!s_ff.editing) begin
            if (key_edit_i && !s_ff.pend) begin
                nxt_s.editing = 1'b1;
                nxt_s.ebuf    = s_ff.eq;
                nxt_s.cursor  = 4'h0;
            end
        end else if (key_back_i) begin
            if (s_ff.cursor == 4'h0)
                nxt_s.editing = 1'b0;
            else
                nxt_s.cursor = s_ff.cursor - 4'h1;
        end else if (key_up_i || key_down_i) begin
            ntok = tok_step(s_ff.ebuf[s_ff.cursor], key_up_i);
            nxt_s.ebuf[s_ff.cursor] = ntok;
            if (tok_cat(ntok) != tok_cat(s_ff.ebuf[s_ff.cursor])) begin
                for (int i = 0; i < `CEE_EQ_LEN; i++) begin
                    if (4'(i) > s_ff.cursor)
                        nxt_s.ebuf[i] = `CEE_TOK_BLANK;
                end
            end
        end else if (key_ack_i) begin
            if (s_ff.ebuf[s_ff.cursor] == `CEE_TOK_BLANK
                || s_ff.cursor == 4'(`CEE_EQ_LEN - 1)) begin
                nxt_s.editing = 1'b0;
                nxt_s.pend    = 1'b1;
            end else begin
                nxt_s.cursor = s_ff.cursor + 4'h1;
            end
        end
        nxt_s.edtok = nxt_s.ebuf[nxt_s.cursor];
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '{ev: EV_IDLE, result: `CEE_RESULT_RST, default: '0};
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign result_o       = s_ff.result;
    assign result_valid_o = s_ff.res_vld;
    // scan and drain share bit 0 of the gray code, so busy is a flop bit
    assign busy_o         = s_ff.ev[0];
    assign editing_o      = s_ff.editing;
    assign cursor_o       = s_ff.cursor;
    assign edit_tok_o     = s_ff.edtok;
endmodule : cee_evaluator

// file: verification/cee_assertions.sv
// Purpose: port-level checks on the equation evaluator
// Assumes: single clock domain, async active-high reset
// Notes:   bound onto every evaluator instance
`timescale 1ns/1ps
module cee_assertions
    import cee_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        calc_tick_i,
    input wire logic        key_ack_i,
    input wire logic        key_back_i,
    input wire logic        key_up_i,
    input wire logic        key_down_i,
    input wire logic [15:0] result_o,
    input wire logic        result_valid_o,
    input wire logic        busy_o,
    input wire logic        editing_o,
    input wire logic [3:0]  cursor_o,
    input wire logic [5:0]  edit_tok_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // back key seen by an active editor
    logic back_k;
    // lone ack key seen by an active editor
    logic ack_k;
    assign back_k = ce_i && editing_o && key_back_i;
    assign ack_k = ce_i && editing_o && key_ack_i && !key_back_i
                   && !key_up_i && !key_down_i;
    tick_start_a: assert property (
        ce_i && calc_tick_i && !busy_o |=> busy_o)
        else $error("tick did not start an evaluation");
    busy_bound_a: assert property (
        $rose(busy_o) |-> ##[1:40] result_valid_o)
        else $error("evaluation did not finish in time");
    valid_idle_a: assert property (
        result_valid_o |-> !busy_o && $past(busy_o))
        else $error("result pulse without a finished evaluation");
    result_hold_a: assert property (
        !result_valid_o |-> $stable(result_o))
        else $error("result changed without a pulse");
    back_abort_a: assert property (
        back_k && cursor_o == 4'h0 |=> !editing_o)
        else $error("back at first position did not abort");
    back_left_a: assert property (
        back_k && cursor_o != 4'h0
        |=> editing_o && cursor_o + 4'h1 == $past(cursor_o))
        else $error("back did not move the cursor left");
    ack_right_a: assert property (
        ack_k && edit_tok_o != 6'h00 && cursor_o < 4'h8
        |=> editing_o && cursor_o == $past(cursor_o) + 4'h1)
        else $error("ack did not move the cursor right");
    ack_commit_a: assert property (
        ack_k && edit_tok_o == 6'h00 |=> !editing_o)
        else $error("ack on blank did not end the entry");
    cursor_max_a: assert property (cursor_o <= 4'h8)
        else $error("cursor beyond ninth position");
    // main scenarios reached
    cover property (result_valid_o);
    cover property (back_k && cursor_o == 4'h0);
    cover property (ack_k && edit_tok_o == 6'h00);
endmodule : cee_assertions

bind cee_evaluator cee_assertions u_cee_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .calc_tick_i(calc_tick_i),
    .key_ack_i(key_ack_i), .key_back_i(key_back_i), .key_up_i(key_up_i),
    .key_down_i(key_down_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .busy_o(busy_o),
    .editing_o(editing_o), .cursor_o(cursor_o), .edit_tok_o(edit_tok_o));

// file: verification/cee_keypad.sv
// Purpose: operator keypad reading the front-panel token display
// Assumes: keys are one-cycle pulses on the core clock
// Notes:   keys_o bits are edit, up, down, ack, back
`timescale 1ns/1ps
module cee_keypad
    import cee_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [5:0] edit_tok_i, // token shown at cursor
    output logic      [4:0] keys_o      // key pulses
);
    initial keys_o = 5'h00;
    // one key pulse, then let the display settle
    task automatic press(input int k);
        @(posedge clk_i) keys_o <= 5'h01 << k;
        @(posedge clk_i) keys_o <= 5'h00;
        #1;
    endtask : press
    // place of a code on the up/down ring of 47 codes
    function automatic int ring(input logic [5:0] c);
        if (c == 6'h00) return 0;
        if (c <= 6'h1b) return int'(c);
        if (c <= 6'h29) return int'(c) - 32 + 28;
        return int'(c) - 48 + 38;
    endfunction : ring
    // key legend to token code, r marks square root
    function automatic logic [5:0] code(input byte ch);
        case (ch)
            "(": return 6'h30;
            "r": return 6'h31;
            ")": return 6'h32;
            "*": return 6'h33;
            "/": return 6'h34;
            "-": return 6'h35;
            "+": return 6'h36;
            ">": return 6'h37;
            "<": return 6'h38;
            default: return (ch < "A") ? 6'(ch - "0" + 32) : 6'(ch - "A" + 1);
        endcase
    endfunction : code
    // whole entry, blank terminated unless nine long, then commit
    task automatic load(input string s);
        int n;
        logic [5:0] t;
        press(0);
        for (int p = 0; p <= s.len() && p < 9; p++) begin
            t = (p < s.len()) ? code(s[p]) : 6'h00;
            n = (ring(t) - ring(edit_tok_i) + 47) % 47;
            repeat (n) press(1);
            press(3);
        end
        repeat (2) @(posedge clk_i);
    endtask : load
endmodule : cee_keypad

// file: verification/testbench.sv
// Purpose: self-checking bench for the equation evaluator
// Assumes: refresh period shortened to 20 cycles
// Notes:   operands A=20 B=4 C=3 D=3 E=0 G=5 H=17
`timescale 1ns/1ps
`include "cee_cfg.svh"
`define CHK(nm, ex, ac) chk(nm, 16'(ex), 16'(ac))
module testbench;
    import cee_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic calc_tick_i = 1'b0;
    cee_val_t opnd [`CEE_NUM_OPND];
    logic [9:0] gates = 10'h000;
    logic [4:0] keys;
    logic [15:0] result_o;
    logic result_valid_o, busy_o, editing_o;
    logic [3:0] cursor_o;
    logic [5:0] edit_tok_o;
    int error_cnt = 0;
    int check_count = 0;
    always #5 clk_i = ~clk_i;
    cee_evaluator #(.GATE_REFRESH_CYC(20)) u_cee_evaluator (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .calc_tick_i(calc_tick_i),
        .operands_i(opnd), .gates_i(gates), .key_edit_i(keys[0]),
        .key_up_i(keys[1]), .key_down_i(keys[2]), .key_ack_i(keys[3]),
        .key_back_i(keys[4]), .result_o(result_o),
        .result_valid_o(result_valid_o), .busy_o(busy_o),
        .editing_o(editing_o), .cursor_o(cursor_o), .edit_tok_o(edit_tok_o));
    cee_keypad u_cee_keypad (.clk_i(clk_i), .edit_tok_i(edit_tok_o),
        .keys_o(keys));
    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, a);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, a);
        end
    endtask : chk
    // one computation cycle, result judged on its pulse
    task automatic ev(input logic [15:0] e, input string nm);
        @(posedge clk_i) calc_tick_i <= 1'b1;
        @(posedge clk_i) calc_tick_i <= 1'b0;
        for (int i = 0; i < 60 && result_valid_o !== 1'b1; i++)
            @(posedge clk_i) #1;
        `CHK("valid", 1'b1, result_valid_o);
        `CHK(nm, e, result_o);
    endtask : ev
    task automatic t_ramp();
        `CHK("busy", 0, busy_o);
        ev(16'h0000, "blank");
        u_cee_keypad.load("X+G");
        ev(16'h0005, "ramp1");
        ev(16'h000a, "ramp2");
        u_cee_keypad.load("X+G)<H");
        ev(16'h000f, "clamp1");
        ev(16'h0011, "clamp2");
    endtask : t_ramp
    task automatic t_prec();
        u_cee_keypad.load("A+B*C");
        ev(16'h0020, "muladd");
        u_cee_keypad.load("A+B0C");
        ev(16'h0017, "gateadd");
        u_cee_keypad.load("C>B>A");
        ev(16'h0014, "hsel");
        u_cee_keypad.load("A<C<B");
        ev(16'h0003, "lsel");
        u_cee_keypad.load("A*B>H");
        ev(16'h0154, "selmul");
    endtask : t_prec
    task automatic t_gate();
        string s;
        @(posedge clk_i) gates <= 10'h155;
        repeat (40) @(posedge clk_i);
        for (int g = 0; g < 10; g++) begin
            s = "A0B";
            s[1] = 8'("0" + g);
            u_cee_keypad.load(s);
            ev((g % 2) ? 16'h0004 : 16'h0014, s);
        end
    endtask : t_gate
    task automatic t_group();
        u_cee_keypad.load("A/B)*(D+H");
        ev(16'h0064, "brackets");
        u_cee_keypad.load("A*rB+C");
        ev(16'h0028, "root");
        u_cee_keypad.load("A/E");
        ev(16'h7fff, "divpos");
        @(posedge clk_i) opnd[0] <= -16'sd3;
        ev(16'h8000, "divneg");
        u_cee_keypad.load("rA");
        ev(16'h0000, "rootneg");
        @(posedge clk_i) opnd[0] <= 16'sd20;
    endtask : t_group
    task automatic t_edit();
        u_cee_keypad.load("A+B");
        ev(16'h0018, "stored");
        u_cee_keypad.press(0);
        u_cee_keypad.press(1);
        u_cee_keypad.press(3);
        `CHK("kept", 6'h36, edit_tok_o);
        u_cee_keypad.press(4);
        `CHK("left", 4'h0, cursor_o);
        u_cee_keypad.press(2);
        u_cee_keypad.press(2);
        u_cee_keypad.press(1);
        u_cee_keypad.press(3);
        `CHK("blanked", 6'h00, edit_tok_o);
        u_cee_keypad.press(4);
        u_cee_keypad.press(4);
        `CHK("abort", 1'b0, editing_o);
        ev(16'h0018, "unchanged");
    endtask : t_edit
    // every operand letter except X reads its own input, then restores it
    task automatic t_opnd();
        string s;
        cee_val_t keep;
        for (int k = 0; k < 26; k++) begin
            if (k != 23) begin
                s = "A";
                s[0] = 8'("A" + k);
                keep = opnd[k];
                @(posedge clk_i) opnd[k] <= 16'(k * 41 - 300);
                u_cee_keypad.load(s);
                ev(16'(k * 41 - 300), s);
                @(posedge clk_i) opnd[k] <= keep;
            end
        end
    endtask : t_opnd
    // clock enable low freezes all, reset in mid-run clears all
    task automatic t_hold();
        u_cee_keypad.load("A+B");
        ev(16'h0018, "before");
        @(posedge clk_i) ce_i <= 1'b0;
        u_cee_keypad.press(0);
        @(posedge clk_i) calc_tick_i <= 1'b1;
        @(posedge clk_i) calc_tick_i <= 1'b0;
        #1;
        `CHK("frozen_edit", 1'b0, editing_o);
        `CHK("frozen_busy", 1'b0, busy_o);
        @(posedge clk_i) ce_i <= 1'b1;
        u_cee_keypad.press(0);
        `CHK("edit_on", 1'b1, editing_o);
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        #1;
        `CHK("rst_result", 16'h0000, result_o);
        `CHK("rst_edit", 1'b0, editing_o);
        ev(16'h0000, "rst_blank");
    endtask : t_hold
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // hang guard
    initial begin
        #1000000;
        error_cnt++;
        summarize();
    end
    // main sequence
    initial begin
        foreach (opnd[i]) opnd[i] = 16'sd0;
        opnd[0] = 16'sd20;
        opnd[1] = 16'sd4;
        opnd[2] = 16'sd3;
        opnd[3] = 16'sd3;
        opnd[6] = 16'sd5;
        opnd[7] = 16'sd17;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ramp();
        t_prec();
        t_gate();
        t_group();
        t_edit();
        t_opnd();
        t_hold();
        summarize();
    end
endmodule : testbench
